// ---- hdl/sep_core.sv ----
`timescale 1ns/100ps
// Contract
// - Device is a serial slave only; serial clock is always an input.
// - All bytes shift most significant bit first; transactions start at select fall.
// - First byte after select falls is the 8-bit opcode.
// - Bit 3 ignored: x110 sets latch, x100 clears it, x101 reads status.
// - Bit 3 ignored: x001 writes status, x011 reads array, x010 writes array.
// - Unknown opcode: ignore input, output tri-stated until select falls again.
// - Select high: ignore input and tri-state output.
// - Hold keeps transaction state, tri-states output, ignores input.
// - Write latch cleared at power-up; set latch before programming.
// - Clear latch command disables programming regardless of protect pin.
// - Status bit 0 is 1 during internal write, else 0.
// - Bit 1 latch, bits 3:2 block level, bit 7 pin protect enable.
// - Bits 6:4 read 0 when idle; all bits read 1 during write.
// - Block level: none, top quarter, top half, whole array read only.
// - Block bits and pin enable need latch, timed write, busy reported.
// - Hardware protection only when protect pin low and pin enable set.
// - Hardware protection refuses status writes; unprotected array writes still allowed.
// - Protect pin low with pin enable set during status write aborts it; started cycles complete.
// - Pin enable cannot clear while hardware protection holds.
// - Array read streams bytes from 16-bit address, wrapping to zero.
// - Array write increments only five low address bits, wrapping in page.
// - Programming starts at select rise right after last data bit.
// - During write only status read accepted; latch clears at cycle end.

module sep_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	always_comb begin
		in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
		out_valid_o = (cnt_ff != '0);
		out_data_o = mem_ff[rd_ptr_ff];
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
		nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		if (flush_i) begin
			nxt_wr_ptr = '0;
			nxt_rd_ptr = '0;
			nxt_cnt = '0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			cnt_ff <= nxt_cnt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push && !flush_i) begin
			mem_ff[wr_ptr_ff] <= in_data_i;
		end
	end
endmodule

module sep_core #(
	parameter int WRITE_CYCLES = sep_pkg::WRITE_CYCLES
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	input wire logic hold_n_i,
	input wire logic wp_n_i,
	output logic so_o,
	output logic so_oe_o
);
	localparam int AW = sep_pkg::ARR_AW;
	localparam int PW = sep_pkg::PAGE_AW;

	function automatic logic opc_is(input logic [7:0] b, input logic [2:0] code);
		opc_is = (b[7:4] == sep_pkg::OPC_HI) && (b[2:0] == code);
	endfunction

	function automatic logic blk_prot(input logic [AW-1:0] a, input logic [1:0] lvl);
		unique case (lvl)
			2'h0: blk_prot = 1'b0;
			2'h1: blk_prot = (a[AW-1:AW-2] == 2'h3);
			2'h2: blk_prot = a[AW-1];
			2'h3: blk_prot = 1'b1;
		endcase
	endfunction

	// Pin synchronisers; stage 3 is only the edge-detect history of stage 2
	logic [sep_pkg::PIN_N-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			// Idle levels: select, hold and protect high, serial clock low
			pin_s1_ff <= 5'h19;
			pin_s2_ff <= 5'h19;
			pin_s3_ff <= 5'h19;
		end else begin
			pin_s1_ff <= {wp_n_i, hold_n_i, si_i, sck_i, cs_n_i};
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
		end
	end

	logic cs_n_s, si_s, hold_n_s, wp_n_s, sck_rise, sck_fall, cs_fall, cs_rise;
	assign cs_n_s = pin_s2_ff[sep_pkg::PIN_CS];
	assign si_s = pin_s2_ff[sep_pkg::PIN_SI];
	assign hold_n_s = pin_s2_ff[sep_pkg::PIN_HOLD];
	assign wp_n_s = pin_s2_ff[sep_pkg::PIN_WP];
	assign sck_rise = pin_s2_ff[sep_pkg::PIN_SCK] && !pin_s3_ff[sep_pkg::PIN_SCK];
	assign sck_fall = !pin_s2_ff[sep_pkg::PIN_SCK] && pin_s3_ff[sep_pkg::PIN_SCK];
	assign cs_fall = !cs_n_s && pin_s3_ff[sep_pkg::PIN_CS];
	assign cs_rise = cs_n_s && !pin_s3_ff[sep_pkg::PIN_CS];

	sep_pkg::sep_state_t state_ff, nxt_state;
	logic [2:0] bit_cnt_ff, nxt_bit_cnt, tx_cnt_ff, nxt_tx_cnt;
	logic [7:0] rx_sr_ff, nxt_rx_sr, tx_sr_ff, nxt_tx_sr, sr_new_ff, nxt_sr_new;
	logic [sep_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
	logic addr_byte_ff, nxt_addr_byte, is_wr_ff, nxt_is_wr;
	logic wel_ff, nxt_wel, ppe_ff, nxt_ppe, busy_ff, nxt_busy;
	logic [1:0] bl_ff, nxt_bl;
	logic [sep_pkg::BUSY_CW-1:0] busy_cnt_ff, nxt_busy_cnt;
	logic [7:0] pbuf_ff [sep_pkg::PAGE_BYTES];
	logic [7:0] nxt_pbuf [sep_pkg::PAGE_BYTES];
	logic [sep_pkg::PAGE_BYTES-1:0] pmask_ff, nxt_pmask;
	logic sr_pend_ff, nxt_sr_pend, sr_abort_ff, nxt_sr_abort;
	logic so_ff, nxt_so, so_oe_ff, nxt_so_oe;
	logic [AW-1:0] fill_addr_ff, nxt_fill_addr;
	logic fill_on_ff, nxt_fill_on;
	logic [7:0] mem_ff [sep_pkg::ARR_DEPTH];
	logic arr_commit, fifo_flush, fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [7:0] fifo_out_data, status_val, new_byte, out_byte;
	logic hw_prot;

	sep_fifo #(.WIDTH(sep_pkg::FIFO_W), .DEPTH(sep_pkg::FIFO_DEPTH)) u_prefetch (
		.clk_i(mclk_i),
		.rst_i(sys_rst_i),
		.flush_i(fifo_flush),
		.in_valid_i(fill_on_ff),
		.in_ready_o(fifo_in_ready),
		.in_data_i(mem_ff[fill_addr_ff]),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_out_data)
	);

	always_comb begin
		nxt_state = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_tx_cnt = tx_cnt_ff;
		nxt_rx_sr = rx_sr_ff;
		nxt_tx_sr = tx_sr_ff;
		nxt_sr_new = sr_new_ff;
		nxt_addr = addr_ff;
		nxt_addr_byte = addr_byte_ff;
		nxt_is_wr = is_wr_ff;
		nxt_wel = wel_ff;
		nxt_ppe = ppe_ff;
		nxt_bl = bl_ff;
		nxt_busy = busy_ff;
		nxt_busy_cnt = busy_cnt_ff;
		nxt_pbuf = pbuf_ff;
		nxt_pmask = pmask_ff;
		nxt_sr_pend = sr_pend_ff;
		nxt_sr_abort = sr_abort_ff;
		nxt_so = so_ff;
		nxt_so_oe = so_oe_ff;
		nxt_fill_addr = fill_addr_ff;
		nxt_fill_on = fill_on_ff;
		arr_commit = 1'b0;
		fifo_flush = 1'b0;
		fifo_pop = 1'b0;
		new_byte = {rx_sr_ff[6:0], si_s};
		out_byte = sep_pkg::IDLE_BYTE;
		hw_prot = !wp_n_s && ppe_ff;
		status_val = '0;
		status_val[sep_pkg::ST_BUSY_BIT] = busy_ff;
		status_val[sep_pkg::ST_WEL_BIT] = wel_ff;
		status_val[sep_pkg::ST_BL_LO_BIT] = bl_ff[0];
		status_val[sep_pkg::ST_BL_HI_BIT] = bl_ff[1];
		status_val[sep_pkg::ST_PPE_BIT] = ppe_ff;
		if (busy_ff) begin
			status_val = sep_pkg::ST_BUSY_VALUE;
		end
		if (fill_on_ff && fifo_in_ready) begin
			nxt_fill_addr = fill_addr_ff + 1'b1;
		end
		if (busy_ff) begin
			if (busy_cnt_ff == sep_pkg::BUSY_CW'(WRITE_CYCLES - 1)) begin
				nxt_busy = 1'b0;
				nxt_wel = 1'b0;
			end else begin
				nxt_busy_cnt = busy_cnt_ff + 1'b1;
			end
		end
		if (cs_rise && bit_cnt_ff == 3'h0) begin
			if (state_ff == sep_pkg::SEP_WDATA && wel_ff && pmask_ff != '0) begin
				arr_commit = 1'b1;
				nxt_busy = 1'b1;
				nxt_busy_cnt = '0;
			end
			if (state_ff == sep_pkg::SEP_SDATA && sr_pend_ff && wel_ff && !hw_prot
					&& !sr_abort_ff) begin
				nxt_bl = {sr_new_ff[sep_pkg::ST_BL_HI_BIT], sr_new_ff[sep_pkg::ST_BL_LO_BIT]};
				nxt_ppe = sr_new_ff[sep_pkg::ST_PPE_BIT];
				nxt_busy = 1'b1;
				nxt_busy_cnt = '0;
			end
		end
		if (cs_n_s) begin
			nxt_state = sep_pkg::SEP_IDLE;
			nxt_so_oe = 1'b0;
			nxt_fill_on = 1'b0;
			fifo_flush = 1'b1;
		end else if (cs_fall) begin
			nxt_state = sep_pkg::SEP_OPC;
			nxt_bit_cnt = '0;
			nxt_tx_cnt = '0;
			nxt_addr_byte = 1'b0;
			nxt_pmask = '0;
			nxt_sr_pend = 1'b0;
			nxt_sr_abort = 1'b0;
		end else if (!hold_n_s) begin
			nxt_so_oe = 1'b0;
		end else begin
			nxt_so_oe = (state_ff == sep_pkg::SEP_STAT) || (state_ff == sep_pkg::SEP_RDATA);
			if (state_ff == sep_pkg::SEP_SDATA && hw_prot) begin
				nxt_sr_abort = 1'b1;
			end
			if (sck_rise && state_ff != sep_pkg::SEP_DEAD && state_ff != sep_pkg::SEP_IDLE) begin
				nxt_rx_sr = new_byte;
				nxt_bit_cnt = bit_cnt_ff + 1'b1;
				if (bit_cnt_ff == 3'h7) begin
					unique case (state_ff)
						sep_pkg::SEP_OPC: begin
							nxt_state = sep_pkg::SEP_DEAD;
							if (busy_ff && !opc_is(new_byte, sep_pkg::OPC_STAT_RD)) begin
								nxt_state = sep_pkg::SEP_DEAD;
							end else if (opc_is(new_byte, sep_pkg::OPC_SET_WEL)) begin
								nxt_wel = 1'b1;
							end else if (opc_is(new_byte, sep_pkg::OPC_CLR_WEL)) begin
								nxt_wel = 1'b0;
							end else if (opc_is(new_byte, sep_pkg::OPC_STAT_RD)) begin
								nxt_state = sep_pkg::SEP_STAT;
							end else if (opc_is(new_byte, sep_pkg::OPC_STAT_WR)) begin
								nxt_state = sep_pkg::SEP_SDATA;
							end else if (opc_is(new_byte, sep_pkg::OPC_ARR_RD)
									|| opc_is(new_byte, sep_pkg::OPC_ARR_WR)) begin
								nxt_state = sep_pkg::SEP_ADDR;
								nxt_is_wr = opc_is(new_byte, sep_pkg::OPC_ARR_WR);
							end
						end
						sep_pkg::SEP_ADDR: begin
							nxt_addr = {addr_ff[7:0], new_byte};
							nxt_addr_byte = 1'b1;
							if (addr_byte_ff) begin
								nxt_state = is_wr_ff ? sep_pkg::SEP_WDATA : sep_pkg::SEP_RDATA;
								nxt_fill_addr = nxt_addr[AW-1:0];
								nxt_fill_on = !is_wr_ff;
								fifo_flush = 1'b1;
							end
						end
						sep_pkg::SEP_WDATA: begin
							nxt_pbuf[addr_ff[PW-1:0]] = new_byte;
							nxt_pmask[addr_ff[PW-1:0]] = !blk_prot(addr_ff[AW-1:0], bl_ff);
							nxt_addr[PW-1:0] = addr_ff[PW-1:0] + 1'b1;
						end
						sep_pkg::SEP_SDATA: begin
							nxt_sr_new = new_byte;
							nxt_sr_pend = 1'b1;
						end
						default: begin
						end
					endcase
				end
			end
			if (sck_fall && nxt_so_oe) begin
				if (tx_cnt_ff == 3'h0) begin
					if (state_ff == sep_pkg::SEP_STAT) begin
						out_byte = status_val;
					end else if (fifo_out_valid) begin
						out_byte = fifo_out_data;
						fifo_pop = 1'b1;
					end
					nxt_so = out_byte[7];
					nxt_tx_sr = {out_byte[6:0], 1'b0};
				end else begin
					nxt_so = tx_sr_ff[7];
					nxt_tx_sr = {tx_sr_ff[6:0], 1'b0};
				end
				nxt_tx_cnt = tx_cnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_ff <= sep_pkg::SEP_IDLE;
			bit_cnt_ff <= '0;
			tx_cnt_ff <= '0;
			rx_sr_ff <= '0;
			tx_sr_ff <= '0;
			sr_new_ff <= '0;
			addr_ff <= '0;
			addr_byte_ff <= 1'b0;
			is_wr_ff <= 1'b0;
			wel_ff <= sep_pkg::WEL_RST;
			ppe_ff <= sep_pkg::PPE_RST;
			bl_ff <= sep_pkg::BLOCK_RST;
			busy_ff <= 1'b0;
			busy_cnt_ff <= '0;
			pmask_ff <= '0;
			sr_pend_ff <= 1'b0;
			sr_abort_ff <= 1'b0;
			so_ff <= 1'b0;
			so_oe_ff <= 1'b0;
			fill_addr_ff <= '0;
			fill_on_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			tx_cnt_ff <= nxt_tx_cnt;
			rx_sr_ff <= nxt_rx_sr;
			tx_sr_ff <= nxt_tx_sr;
			sr_new_ff <= nxt_sr_new;
			addr_ff <= nxt_addr;
			addr_byte_ff <= nxt_addr_byte;
			is_wr_ff <= nxt_is_wr;
			wel_ff <= nxt_wel;
			ppe_ff <= nxt_ppe;
			bl_ff <= nxt_bl;
			busy_ff <= nxt_busy;
			busy_cnt_ff <= nxt_busy_cnt;
			pmask_ff <= nxt_pmask;
			sr_pend_ff <= nxt_sr_pend;
			sr_abort_ff <= nxt_sr_abort;
			so_ff <= nxt_so;
			so_oe_ff <= nxt_so_oe;
			fill_addr_ff <= nxt_fill_addr;
			fill_on_ff <= nxt_fill_on;
		end
	end

	// Page buffer and array hold no reset: contents are data, not control
	always_ff @(posedge mclk_i) begin
		pbuf_ff <= nxt_pbuf;
		for (int i = 0; i < sep_pkg::PAGE_BYTES; i++) begin
			if (arr_commit && pmask_ff[i]) begin
				mem_ff[{addr_ff[AW-1:PW], PW'(i)}] <= pbuf_ff[i];
			end
		end
	end

	assign so_o = so_ff;
	assign so_oe_o = so_oe_ff;
endmodule

// ---- shared/sep_pkg.sv ----
package sep_pkg;
	// Array geometry: smallest family member, 1024 bytes, 32-byte pages
	localparam int ARR_AW = 10;
	localparam int ARR_DEPTH = 1024;
	localparam int PAGE_AW = 5;
	localparam int PAGE_BYTES = 32;
	localparam int ADDR_W = 16;
	// Opcodes: upper nibble zero, bit 3 ignored, low three bits select
	localparam logic [3:0] OPC_HI = 4'h0;
	localparam logic [2:0] OPC_SET_WEL = 3'h6;
	localparam logic [2:0] OPC_CLR_WEL = 3'h4;
	localparam logic [2:0] OPC_STAT_RD = 3'h5;
	localparam logic [2:0] OPC_STAT_WR = 3'h1;
	localparam logic [2:0] OPC_ARR_RD = 3'h3;
	localparam logic [2:0] OPC_ARR_WR = 3'h2;
	// Status field positions
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WEL_BIT = 1;
	localparam int ST_BL_LO_BIT = 2;
	localparam int ST_BL_HI_BIT = 3;
	localparam int ST_PPE_BIT = 7;
	localparam logic [7:0] ST_BUSY_VALUE = 8'hff;
	// Values after reset, and the byte sent when no read data is ready
	localparam logic [1:0] BLOCK_RST = 2'h0;
	localparam logic PPE_RST = 1'b0;
	localparam logic WEL_RST = 1'b0;
	localparam logic [7:0] IDLE_BYTE = 8'hff;
	// Self-timed write cycle
	localparam int CLK_PERIOD_NS = 5;
	localparam int WRITE_TIME_NS = 5000000;
	localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int BUSY_CW = 20;
	// Read prefetch buffer
	localparam int FIFO_W = 8;
	localparam int FIFO_DEPTH = 8;
	// Synchronised pin vector positions
	localparam int PIN_CS = 0;
	localparam int PIN_SCK = 1;
	localparam int PIN_SI = 2;
	localparam int PIN_HOLD = 3;
	localparam int PIN_WP = 4;
	localparam int PIN_N = 5;

	typedef enum logic [2:0] {
		SEP_IDLE, SEP_OPC, SEP_ADDR, SEP_WDATA, SEP_SDATA, SEP_STAT, SEP_RDATA, SEP_DEAD
	} sep_state_t;
endpackage

// ---- verif/sep_core_monitor.sv ----
`timescale 1ns/100ps
module sep_core_monitor (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic hold_n_i,
	input wire logic so_o,
	input wire logic so_oe_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	idle_tristate_a: assert property (cs_n_i [*4] |-> !so_oe_o)
		else $error("output driven while deselected");
	hold_tristate_a: assert property (!hold_n_i [*4] |-> !so_oe_o)
		else $error("output driven during hold");
	opcode_first_a: assert property ($fell(cs_n_i) |=> !so_oe_o [*8])
		else $error("output enabled before opcode");
	oe_rise_a: assert property ($rose(so_oe_o) |-> !cs_n_i && hold_n_i)
		else $error("output enabled without select");
	oe_fall_a: assert property ($fell(so_oe_o) |-> $past(cs_n_i, 2) || !$past(hold_n_i, 2))
		else $error("output released without cause");
	so_fall_edge_a: assert property (
		so_oe_o && $past(so_oe_o) && $changed(so_o) |-> !$past(sck_i, 2))
		else $error("data changed after rising clock");
	so_hold_rise_a: assert property ($rose(sck_i) && so_oe_o |=> $stable(so_o) [*2])
		else $error("data moved at rising clock");
	oe_steady_a: assert property (
		(!cs_n_i && hold_n_i) [*5] ##0 so_oe_o |=> so_oe_o)
		else $error("output dropped mid frame");
	cover property ($rose(so_oe_o));
	cover property (so_oe_o ##1 !hold_n_i);
	cover property ($fell(cs_n_i) ##[1:300] $rose(cs_n_i));
endmodule

// ---- verif/sep_spi_master.sv ----
`timescale 1ns/100ps
module sep_spi_master (
	input wire logic so_i,
	input wire logic so_oe_i,
	output logic cs_n_o,
	output logic sck_o,
	output logic si_o,
	output logic hold_n_o
);
	int oe_seen;
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
		hold_n_o = 1'b1;
	end
	// Integer-ns link timing never lands on an mclk rising edge
	task automatic sel();
		cs_n_o = 1'b0;
		oe_seen = 0;
		#80;
	endtask
	task automatic desel();
		#16;
		cs_n_o = 1'b1;
		si_o = ~si_o;
		#120;
	endtask
	task automatic xfer(input logic [7:0] t, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			si_o = t[i];
			#32;
			sck_o = 1'b1;
			// A released output reads as the inverse of its last level
			r[i] = so_oe_i ? so_i : ~so_i;
			oe_seen += int'(so_oe_i);
			#32;
			sck_o = 1'b0;
		end
	endtask
	task automatic pause(input int n);
		// Lower hold well inside the clock low time, after the falling edge
		#16 hold_n_o = 1'b0;
		repeat (n) begin
			#32 sck_o = 1'b1;
			si_o = 1'($urandom);
			#32 sck_o = 1'b0;
		end
		#32 hold_n_o = 1'b1;
		#32;
	endtask
endmodule

// ---- verif/spi_eeprom_command_protect_tb_top.sv ----
`timescale 1ns/100ps
module spi_eeprom_command_protect_tb_top;
	localparam int WC = 1200;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wp_n_i = 1'b1;
	logic cs_n, sck, si, hold_n, so_o, so_oe_o;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [7:0] mem [int];
	logic wel = 1'b0;
	logic ppe = 1'b0;
	logic bz = 1'b0;
	logic [1:0] bl = 2'h0;
	sep_core #(.WRITE_CYCLES(WC)) DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n),
		.sck_i(sck), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so_o),
		.so_oe_o(so_oe_o));
	sep_spi_master M (.so_i(so_o), .so_oe_i(so_oe_o), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
		.hold_n_o(hold_n));
	initial begin
		forever #2.5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			conclude();
		end
	end
	function automatic logic [7:0] stx();
		return {ppe, 3'h0, bl, wel, 1'b0};
	endfunction
	function automatic logic prot(input int a);
		return bl == 2'h3 || (bl == 2'h2 && a[9]) || (bl == 2'h1 && a[9:8] == 2'h3);
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic done(input string s);
		$display("test %s complete", s);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic setwp(input logic v);
		@(posedge mclk_i);
		wp_n_i <= v;
		@(negedge mclk_i);
	endtask
	task automatic cmd(input logic [7:0] op);
		logic [7:0] r;
		M.sel();
		M.xfer(op, r);
		M.desel();
		if (!bz) wel = op[1];
	endtask
	task automatic stat_rd(input logic [7:0] op, input logic h);
		logic [7:0] r;
		M.sel();
		M.xfer(op, r);
		if (h) M.pause(3);
		M.xfer(8'h00, r);
		check(r, bz ? 8'hff : stx());
		M.desel();
	endtask
	task automatic fin();
		logic [7:0] r;
		if (bz) begin
			cmd(8'h06);
			// Array read while busy must never enable the output
			M.sel();
			repeat (4) M.xfer(8'h03, r);
			M.desel();
			check(8'(M.oe_seen), 8'h00);
			stat_rd(8'h05, 1'b0);
			#(WC * 5);
			bz = 1'b0;
			wel = 1'b0;
		end
		stat_rd(8'h05, 1'b0);
	endtask
	task automatic wr(input logic [7:0] op, input int a, input int n);
		logic [7:0] r;
		logic [7:0] d;
		logic go;
		logic ok;
		int p;
		go = wel && !bz;
		ok = 1'b0;
		M.sel();
		M.xfer(op, r);
		M.xfer(a[15:8], r);
		M.xfer(a[7:0], r);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			p = (a & 32'h3e0) | ((a + i) & 32'h1f);
			M.xfer(d, r);
			if (go && !prot(p)) begin
				mem[p] = d;
				ok = 1'b1;
			end
		end
		M.desel();
		bz = ok;
		fin();
	endtask
	task automatic stat_wr(input logic [7:0] op, input logic [7:0] v, input logic drop);
		logic [7:0] r;
		logic ok;
		ok = wel && !bz && !(ppe && !wp_n_i) && !drop;
		M.sel();
		M.xfer(op, r);
		if (drop) setwp(1'b0);
		M.xfer(v, r);
		if (drop) setwp(1'b1);
		M.desel();
		if (ok) begin
			{ppe, bl} = {v[7], v[3:2]};
			bz = 1'b1;
		end
		fin();
	endtask
	task automatic rd(input int a, input int n);
		logic [7:0] r;
		int p;
		M.sel();
		M.xfer(8'h0b, r);
		M.xfer(a[15:8], r);
		M.xfer(a[7:0], r);
		for (int i = 0; i < n; i++) begin
			M.xfer(8'h00, r);
			p = (a + i) % 1024;
			if (mem.exists(p)) check(r, mem[p]);
		end
		M.desel();
	endtask
	initial begin
		logic [7:0] r;
		void'($urandom(34));
		repeat (4) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		@(negedge mclk_i);
		stat_rd(8'h05, 1'b0);
		cmd(8'h0e);
		stat_rd(8'h0d, 1'b1);
		setwp(1'b0);
		cmd(8'h04);
		stat_rd(8'h05, 1'b0);
		setwp(1'b1);
		done("latch");
		cmd(8'h06);
		wr(8'h0a, 32'h1e, 3);
		wr(8'h02, 32'h1e, 3);
		cmd(8'h06);
		wr(8'h02, 32'h3ff, 1);
		rd(32'h1e, 2);
		rd(32'h3ff, 2);
		done("array");
		cmd(8'h06);
		stat_wr(8'h09, 8'h84, 1'b0);
		cmd(8'h06);
		wr(8'h02, 32'h300, 1);
		wr(8'h02, 32'h2ff, 1);
		rd(32'h2ff, 1);
		done("block");
		// Latch set so that only the protect pin can refuse what follows
		cmd(8'h06);
		stat_wr(8'h01, 8'h00, 1'b1);
		setwp(1'b0);
		stat_wr(8'h01, 8'h00, 1'b0);
		wr(8'h02, 32'h100, 1);
		rd(32'h100, 1);
		setwp(1'b1);
		cmd(8'h06);
		stat_wr(8'h01, 8'h00, 1'b0);
		done("protect");
		M.sel();
		M.xfer(8'h10, r);
		M.xfer(8'h05, r);
		M.desel();
		check(8'(M.oe_seen), 8'h00);
		stat_rd(8'h05, 1'b0);
		done("invalid");
		conclude();
	end
endmodule
bind sep_core sep_core_monitor MON (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i),
	.sck_i(sck_i), .hold_n_i(hold_n_i), .so_o(so_o), .so_oe_o(so_oe_o));
